// File: rtl/dcrb_pkg.sv
// Package of register map, reset values and field positions for the config register bank
`default_nettype none
package dcrb_pkg;
  // ==========================================================
  // Serial frame layout
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_W = 13;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam int INSTR_RW_BIT = 15;
  // ==========================================================
  // Register addresses
  localparam logic [12:0] A_PORT_CFG = 13'h000;
  localparam logic [12:0] A_CHIP_ID = 13'h001;
  localparam logic [12:0] A_GRADE = 13'h002;
  localparam logic [12:0] A_CHAN_SEL = 13'h005;
  localparam logic [12:0] A_COMMIT = 13'h0FF;
  localparam logic [12:0] A_PROG_LO = 13'h008;
  localparam logic [12:0] A_SHADOW_HI = 13'h018;
  localparam logic [12:0] A_PROG_HI = 13'h02E;
  localparam logic [12:0] A_CLOCK = 13'h009;
  localparam logic [12:0] A_OUT_MODE = 13'h014;
  localparam logic [12:0] A_DIG_LO = 13'h100;
  localparam logic [12:0] A_DIG_HI = 13'h11D;
  // ==========================================================
  // Array sizes and indices derived from the map
  localparam int PROG_N = 39;
  localparam int SHADOW_N = 17;
  localparam int DIG_N = 30;
  localparam int IDX_MODES = 0;
  localparam int IDX_CLOCK = 1;
  localparam int IDX_OUT_MODE = 12;
  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [1:0] CHAN_SEL_RST = 2'h3;
  localparam logic [7:0] MODES_RST = 8'h80;
  localparam logic [7:0] CLOCK_RST = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int PORT_LSB_HI = 6;
  localparam int PORT_LSB_LO = 1;
  localparam int PORT_SRST_HI = 5;
  localparam int PORT_SRST_LO = 2;
  localparam int COMMIT_BIT = 0;
  localparam int CHAN_A = 0;
  localparam int CHAN_B = 1;
  localparam int CLOCK_STAB_BIT = 0;
  localparam logic [1:0] FMT_TWOS = 2'h1;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // ==========================================================
  // Serial engine states
  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} dcrb_state_t;
  // Default of a program location by index
  function automatic logic [7:0] prog_default(input int idx);
    prog_default = (idx == IDX_MODES) ? MODES_RST : ((idx == IDX_CLOCK) ? CLOCK_RST : ZERO_BYTE);
  endfunction
endpackage
`default_nettype wire

// File: rtl/dcrb_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous levels
`default_nettype none
module dcrb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ==========================================================
  // Stages
  logic [W-1:0] meta_r; // First stage, read only by the second
  // Only the second stage is visible to logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // dcrb_sync
`default_nettype wire

// File: rtl/dcrb_reg_bank.sv
// Dual-channel configuration register bank behind a three-wire serial port
`default_nettype none
module dcrb_reg_bank #(
  parameter logic [7:0] CHIP_ID = 8'h5A, // Arbitrary value
  parameter logic [2:0] SPEED_GRADE = 3'h0 // Arbitrary value
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic SERIAL_SELECT_N,
  input wire logic SHIFT_CLOCK_FORMAT_STRAP,
  input wire logic SERIAL_IO_STABILIZER_STRAP_IN,
  output logic SERIAL_IO_STABILIZER_STRAP_OUT,
  output logic SERIAL_IO_STABILIZER_STRAP_OE,
  input wire logic OUTPUT_DISABLE_PIN,
  input wire logic POWERDOWN_PIN,
  output logic DUTY_CYCLE_STABILIZER,
  output logic DATA_FORMAT_SELECT,
  output logic DATA_OUTPUTS_ENABLE,
  output logic POWERDOWN_ACTIVE,
  output logic SERIAL_PORT_ENABLED,
  output logic [7:0] ACTIVE_MODES_A,
  output logic [7:0] ACTIVE_MODES_B
);
  // ==========================================================
  // Reset release
  logic [1:0] rst_pipe_r; // Release pipeline
  logic rst_n; // Synchronised reset used everywhere
  // Assert at once, release two edges later
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_r[1];

  // ==========================================================
  // Pin synchronisers
  logic [4:0] pins_q; // Synchronised pin levels
  logic sel_q; // Serial select, low in a frame
  logic sclk_q; // Shift clock / format strap
  logic sdi_q; // Data in / stabilizer strap
  logic oeb_q; // Output disable pin
  logic powerdown_pin_q; // Power-down pin
  dcrb_sync #(.W(5)) u_sync (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .d({SERIAL_SELECT_N, SHIFT_CLOCK_FORMAT_STRAP, SERIAL_IO_STABILIZER_STRAP_IN,
        OUTPUT_DISABLE_PIN, POWERDOWN_PIN}),
    .q(pins_q)
  );
  assign {sel_q, sclk_q, sdi_q, oeb_q, powerdown_pin_q} = pins_q;

  // ==========================================================
  // Strap capture
  logic [1:0] strap_wait_r; // Lets the synchroniser fill first
  logic strap_done_r; // Straps captured
  logic port_en_r; // Serial port enabled
  logic strap_stab_r; // Captured stabilizer strap
  logic strap_fmt_r; // Captured format strap
  // Sampled once after release; the levels are held for good since the
  // pins become serial signals later and must not steer the converter
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait_r <= 2'h0;
      strap_done_r <= 1'b0;
      port_en_r <= 1'b0;
      strap_stab_r <= 1'b1;
      strap_fmt_r <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_wait_r == dcrb_pkg::STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        port_en_r <= ~sel_q;
        strap_stab_r <= sdi_q;
        strap_fmt_r <= sclk_q;
      end else begin
        strap_wait_r <= strap_wait_r + 2'h1;
      end
    end
  end

  // ==========================================================
  // Serial engine
  logic sclk_d_r; // Previous shift clock level
  logic sclk_rise; // Sampling edge
  logic sclk_fall; // Launch edge for read data
  logic frame_act; // Port enabled and selected
  dcrb_pkg::dcrb_state_t state_r; // Frame phase
  logic [3:0] bit_cnt_r; // Bits within phase
  logic [15:0] shift_r; // Incoming bits
  logic [15:0] word_in; // Shift register with the new bit
  logic [15:0] instr; // Instruction in MSB-first order
  logic [7:0] byte_in; // Data byte in MSB-first order
  logic [12:0] addr_r; // Current location
  logic is_read_r; // Frame is a read
  logic wr_en_r; // One-cycle write strobe
  logic [12:0] wr_addr_r; // Write location
  logic [7:0] wr_data_r; // Write byte
  logic load_tx_r; // Fetch the next read byte
  logic lsb_first_r; // Shift order

  // Bit order swap for LSB-first mode
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < dcrb_pkg::INSTR_BITS; i++) begin
      rev16[i] = v[dcrb_pkg::INSTR_BITS-1-i];
    end
  endfunction
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < dcrb_pkg::BYTE_BITS; i++) begin
      rev8[i] = v[dcrb_pkg::BYTE_BITS-1-i];
    end
  endfunction

  assign sclk_rise = sclk_q & ~sclk_d_r;
  assign sclk_fall = ~sclk_q & sclk_d_r;
  assign frame_act = port_en_r & strap_done_r & ~sel_q;
  assign word_in = {shift_r[14:0], sdi_q};
  assign instr = lsb_first_r ? rev16(word_in) : word_in;
  assign byte_in = lsb_first_r ? rev8(word_in[7:0]) : word_in[7:0];

  // Edge history of the shift clock
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_q;
    end
  end

  // Frame sequencing: instruction, then bytes until select rises
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= dcrb_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 16'h0000;
      addr_r <= 13'h0000;
      is_read_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_addr_r <= 13'h0000;
      wr_data_r <= 8'h00;
      load_tx_r <= 1'b0;
    end else begin
      wr_en_r <= 1'b0;
      load_tx_r <= 1'b0;
      if (!frame_act) begin
        // Select high ends any frame, even mid-byte
        state_r <= dcrb_pkg::ST_IDLE;
        bit_cnt_r <= 4'h0;
      end else begin
        case (state_r)
          dcrb_pkg::ST_IDLE: begin
            state_r <= dcrb_pkg::ST_INSTR;
            bit_cnt_r <= 4'h0;
          end
          dcrb_pkg::ST_INSTR: begin
            if (sclk_rise) begin
              shift_r <= word_in;
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == dcrb_pkg::INSTR_LAST) begin
                is_read_r <= instr[dcrb_pkg::INSTR_RW_BIT];
                addr_r <= instr[dcrb_pkg::ADDR_W-1:0];
                load_tx_r <= instr[dcrb_pkg::INSTR_RW_BIT];
                state_r <= dcrb_pkg::ST_DATA;
                bit_cnt_r <= 4'h0;
              end
            end
          end
          dcrb_pkg::ST_DATA: begin
            if (sclk_rise) begin
              shift_r <= word_in;
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == dcrb_pkg::BYTE_LAST) begin
                // Byte complete: write it on a write frame, then stream to next location
                wr_en_r <= ~is_read_r;
                wr_addr_r <= addr_r;
                wr_data_r <= byte_in;
                addr_r <= addr_r + 13'h0001;
                load_tx_r <= is_read_r;
                bit_cnt_r <= 4'h0;
              end
            end
          end
          default: begin
            state_r <= dcrb_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register storage
  logic [1:0] chan_sel_r; // Channel select bits
  logic [7:0] prog_r [2][dcrb_pkg::PROG_N]; // Local program copies
  logic [7:0] act_r [2][dcrb_pkg::SHADOW_N]; // Applied shadow copies
  logic [7:0] dig_r [dcrb_pkg::DIG_N]; // Global digital block
  logic [5:0] prog_idx; // Program index of write
  logic [4:0] dig_idx; // Digital index of write
  logic wr_prog; // Write hits program area
  logic wr_dig; // Write hits digital area
  logic soft_rst; // Soft reset request
  logic commit; // Commit request

  assign prog_idx = 6'(wr_addr_r - dcrb_pkg::A_PROG_LO);
  assign dig_idx = 5'(wr_addr_r - dcrb_pkg::A_DIG_LO);
  assign wr_prog = wr_en_r && wr_addr_r >= dcrb_pkg::A_PROG_LO && wr_addr_r <= dcrb_pkg::A_PROG_HI;
  assign wr_dig = wr_en_r && wr_addr_r >= dcrb_pkg::A_DIG_LO && wr_addr_r <= dcrb_pkg::A_DIG_HI;
  assign soft_rst = wr_en_r && wr_addr_r == dcrb_pkg::A_PORT_CFG
    && (wr_data_r[dcrb_pkg::PORT_SRST_HI] || wr_data_r[dcrb_pkg::PORT_SRST_LO]);
  // Bit 0 clear leaves applied copies alone; the request lives one cycle, so it clears itself
  assign commit = wr_en_r && wr_addr_r == dcrb_pkg::A_COMMIT
    && wr_data_r[dcrb_pkg::COMMIT_BIT];

  // Port order; either mirrored bit sets LSB first
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lsb_first_r <= 1'b0;
    end else if (soft_rst) begin
      lsb_first_r <= 1'b0;
    end else if (wr_en_r && wr_addr_r == dcrb_pkg::A_PORT_CFG) begin
      lsb_first_r <= wr_data_r[dcrb_pkg::PORT_LSB_HI] | wr_data_r[dcrb_pkg::PORT_LSB_LO];
    end
  end

  // Channel select; open bits are not stored
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      chan_sel_r <= dcrb_pkg::CHAN_SEL_RST;
    end else if (soft_rst) begin
      chan_sel_r <= dcrb_pkg::CHAN_SEL_RST;
    end else if (wr_en_r && wr_addr_r == dcrb_pkg::A_CHAN_SEL) begin
      chan_sel_r <= wr_data_r[1:0];
    end
  end

  // Program area: one copy per channel, steered by the select bits
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        for (int i = 0; i < dcrb_pkg::PROG_N; i++) begin
          prog_r[c][i] <= dcrb_pkg::prog_default(i);
        end
      end
    end else if (soft_rst) begin
      for (int c = 0; c < 2; c++) begin
        for (int i = 0; i < dcrb_pkg::PROG_N; i++) begin
          prog_r[c][i] <= dcrb_pkg::prog_default(i);
        end
      end
    end else if (wr_prog) begin
      for (int c = 0; c < 2; c++) begin
        if (chan_sel_r[c]) begin
          prog_r[c][prog_idx] <= wr_data_r;
        end
      end
    end
  end

  // Applied copies of the shadowed span change only on commit or soft reset
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        for (int i = 0; i < dcrb_pkg::SHADOW_N; i++) begin
          act_r[c][i] <= dcrb_pkg::prog_default(i);
        end
      end
    end else if (soft_rst) begin
      for (int c = 0; c < 2; c++) begin
        for (int i = 0; i < dcrb_pkg::SHADOW_N; i++) begin
          act_r[c][i] <= dcrb_pkg::prog_default(i);
        end
      end
    end else if (commit) begin
      for (int c = 0; c < 2; c++) begin
        for (int i = 0; i < dcrb_pkg::SHADOW_N; i++) begin
          act_r[c][i] <= prog_r[c][i];
        end
      end
    end
  end

  // Digital area is global, select bits ignored
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < dcrb_pkg::DIG_N; i++) begin
        dig_r[i] <= dcrb_pkg::ZERO_BYTE;
      end
    end else if (soft_rst) begin
      for (int i = 0; i < dcrb_pkg::DIG_N; i++) begin
        dig_r[i] <= dcrb_pkg::ZERO_BYTE;
      end
    end else if (wr_dig) begin
      dig_r[dig_idx] <= wr_data_r;
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] rdata; // Byte at the current location
  logic [5:0] rd_prog_idx; // Program index of read
  logic [4:0] rd_dig_idx; // Digital index of read
  assign rd_prog_idx = 6'(addr_r - dcrb_pkg::A_PROG_LO);
  assign rd_dig_idx = 5'(addr_r - dcrb_pkg::A_DIG_LO);

  // Unmapped and write-only locations read as zero
  always_comb begin
    rdata = dcrb_pkg::ZERO_BYTE;
    if (addr_r == dcrb_pkg::A_PORT_CFG) begin
      rdata = dcrb_pkg::PORT_CFG_RST;
      rdata[dcrb_pkg::PORT_LSB_HI] = lsb_first_r;
      rdata[dcrb_pkg::PORT_LSB_LO] = lsb_first_r;
    end else if (addr_r == dcrb_pkg::A_CHIP_ID) begin
      rdata = CHIP_ID;
    end else if (addr_r == dcrb_pkg::A_GRADE) begin
      rdata = {1'b0, SPEED_GRADE, 4'h0};
    end else if (addr_r == dcrb_pkg::A_CHAN_SEL) begin
      rdata = {6'h00, chan_sel_r};
    end else if (addr_r >= dcrb_pkg::A_PROG_LO && addr_r <= dcrb_pkg::A_PROG_HI) begin
      // Channel A wins when both are selected
      rdata = chan_sel_r[dcrb_pkg::CHAN_A] ? prog_r[dcrb_pkg::CHAN_A][rd_prog_idx]
        : prog_r[dcrb_pkg::CHAN_B][rd_prog_idx];
    end else if (addr_r >= dcrb_pkg::A_DIG_LO && addr_r <= dcrb_pkg::A_DIG_HI) begin
      rdata = dig_r[rd_dig_idx];
    end
  end

  // Read shifter: loaded a cycle after the address settles, launched on falling edges
  logic [7:0] tx_r; // Outgoing byte, next bit on top
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= 8'h00;
      SERIAL_IO_STABILIZER_STRAP_OUT <= 1'b0;
      SERIAL_IO_STABILIZER_STRAP_OE <= 1'b0;
    end else if (!frame_act) begin
      SERIAL_IO_STABILIZER_STRAP_OE <= 1'b0;
    end else if (load_tx_r) begin
      tx_r <= lsb_first_r ? rev8(rdata) : rdata;
      SERIAL_IO_STABILIZER_STRAP_OE <= 1'b1;
    end else if (sclk_fall && SERIAL_IO_STABILIZER_STRAP_OE) begin
      SERIAL_IO_STABILIZER_STRAP_OUT <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // ==========================================================
  // Static controls
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DUTY_CYCLE_STABILIZER <= 1'b1;
      DATA_FORMAT_SELECT <= 1'b0;
      DATA_OUTPUTS_ENABLE <= 1'b0;
      POWERDOWN_ACTIVE <= 1'b0;
      SERIAL_PORT_ENABLED <= 1'b0;
      ACTIVE_MODES_A <= dcrb_pkg::MODES_RST;
      ACTIVE_MODES_B <= dcrb_pkg::MODES_RST;
    end else begin
      if (port_en_r) begin
        DUTY_CYCLE_STABILIZER <= act_r[dcrb_pkg::CHAN_A][dcrb_pkg::IDX_CLOCK][dcrb_pkg::CLOCK_STAB_BIT];
        DATA_FORMAT_SELECT <= act_r[dcrb_pkg::CHAN_A][dcrb_pkg::IDX_OUT_MODE][1:0] == dcrb_pkg::FMT_TWOS;
      end else begin
        DUTY_CYCLE_STABILIZER <= strap_stab_r;
        DATA_FORMAT_SELECT <= strap_fmt_r;
      end
      DATA_OUTPUTS_ENABLE <= ~oeb_q;
      POWERDOWN_ACTIVE <= powerdown_pin_q;
      SERIAL_PORT_ENABLED <= port_en_r;
      ACTIVE_MODES_A <= act_r[dcrb_pkg::CHAN_A][dcrb_pkg::IDX_MODES];
      ACTIVE_MODES_B <= act_r[dcrb_pkg::CHAN_B][dcrb_pkg::IDX_MODES];
    end
  end
endmodule // dcrb_reg_bank
`default_nettype wire

// File: verif/dcrb_checker.sv
// Port-level assertion checker for the configuration register bank
`default_nettype none
module dcrb_checker (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic SERIAL_SELECT_N,
  input wire logic OUTPUT_DISABLE_PIN,
  input wire logic POWERDOWN_PIN,
  input wire logic SERIAL_IO_STABILIZER_STRAP_OE,
  input wire logic DUTY_CYCLE_STABILIZER,
  input wire logic DATA_FORMAT_SELECT,
  input wire logic DATA_OUTPUTS_ENABLE,
  input wire logic POWERDOWN_ACTIVE,
  input wire logic SERIAL_PORT_ENABLED,
  input wire logic [7:0] ACTIVE_MODES_A,
  input wire logic [7:0] ACTIVE_MODES_B
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Reset age
  // Saturating edge count since release; the internal reset copy lags, so early cycles are skipped
  logic [3:0] age_r;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      age_r <= 4'h0;
    end else if (age_r != 4'hF) begin
      age_r <= age_r + 4'h1;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // ==========================================================
  // Assertions
  AST_RST_DEFAULTS:
    assert property (age_r == 4'h1 |-> DUTY_CYCLE_STABILIZER && !DATA_FORMAT_SELECT
      && ACTIVE_MODES_A == 8'h80 && ACTIVE_MODES_B == 8'h80) else $error("Reset defaults wrong");
  AST_OUT_FLOAT:
    assert property ((OUTPUT_DISABLE_PIN && age_r[3])[*4] |=> !DATA_OUTPUTS_ENABLE) else $error("Outputs not floated");
  AST_OUT_DRIVE:
    assert property ((!OUTPUT_DISABLE_PIN && age_r[3])[*4] |=> DATA_OUTPUTS_ENABLE) else $error("Outputs not driven");
  AST_PD_ON:
    assert property ((POWERDOWN_PIN && age_r[3])[*4] |=> POWERDOWN_ACTIVE) else $error("Power-down missed");
  AST_PD_OFF:
    assert property ((!POWERDOWN_PIN && age_r[3])[*4] |=> !POWERDOWN_ACTIVE) else $error("Power-down stuck");
  AST_OE_IDLE:
    assert property (SERIAL_SELECT_N[*5] |-> !SERIAL_IO_STABILIZER_STRAP_OE) else $error("Data pin driven idle");
  AST_OFF_QUIET:
    assert property (!SERIAL_PORT_ENABLED |-> !SERIAL_IO_STABILIZER_STRAP_OE) else $error("Disabled port drives");
  AST_PORT_FIXED:
    assert property (age_r == 4'hF |=> $stable(SERIAL_PORT_ENABLED)) else $error("Port mode changed");
  AST_STRAP_HELD:
    assert property (age_r == 4'hF && !SERIAL_PORT_ENABLED |=> $stable({DUTY_CYCLE_STABILIZER, DATA_FORMAT_SELECT}))
      else $error("Strap setting moved");
  AST_COMMIT_ONLY:
    assert property ((SERIAL_SELECT_N && age_r[3])[*8] |=> $stable(ACTIVE_MODES_A) && $stable(ACTIVE_MODES_B))
      else $error("Active modes moved idle");
  // ==========================================================
  // Covers
  COV_READ: cover property ($rose(SERIAL_IO_STABILIZER_STRAP_OE));
  COV_COMMIT: cover property ($changed(ACTIVE_MODES_A));
  COV_PORT_OFF: cover property (age_r == 4'hF && !SERIAL_PORT_ENABLED);
endmodule // dcrb_checker
bind dcrb_reg_bank dcrb_checker u_checker (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .SERIAL_SELECT_N(SERIAL_SELECT_N),
  .OUTPUT_DISABLE_PIN(OUTPUT_DISABLE_PIN), .POWERDOWN_PIN(POWERDOWN_PIN),
  .SERIAL_IO_STABILIZER_STRAP_OE(SERIAL_IO_STABILIZER_STRAP_OE), .DUTY_CYCLE_STABILIZER(DUTY_CYCLE_STABILIZER),
  .DATA_FORMAT_SELECT(DATA_FORMAT_SELECT), .DATA_OUTPUTS_ENABLE(DATA_OUTPUTS_ENABLE),
  .POWERDOWN_ACTIVE(POWERDOWN_ACTIVE), .SERIAL_PORT_ENABLED(SERIAL_PORT_ENABLED),
  .ACTIVE_MODES_A(ACTIVE_MODES_A), .ACTIVE_MODES_B(ACTIVE_MODES_B));
`default_nettype wire

// File: verif/dcrb_host.sv
// Behavioural serial host that frames reads and writes to the register bank
`default_nettype none
module dcrb_host (
  output var logic sel_n,
  output var logic sck,
  output var logic sdo,
  input wire logic sdio
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bit order of the link; the bench flips it after changing the port setup
  logic lsb = 1'b0;
  // ==========================================================
  // Pin levels held while straps are sampled, and idle levels
  task automatic strap(input logic s, input logic c, input logic d);
    sel_n = s;
    sck = c;
    sdo = d;
  endtask
  // One link bit: data set while clock low, sampled on the rise
  task automatic bit_io(input logic b, output logic r);
    sdo = b;
    #160 r = sdio;
    sck = 1'b1;
    #160 sck = 1'b0;
  endtask
  // ==========================================================
  // Whole frame; clock stands still outside it
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [15:0] ins;
    logic r;
    int k;
    ins = {rd, 2'h0, a};
    sel_n = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--) begin
      k = lsb ? 15 - i : i;
      bit_io(ins[k], r);
    end
    // On a read the host drives a toggling level, which shows up if the device fails to drive
    for (int i = 7; i >= 0; i--) begin
      k = lsb ? 7 - i : i;
      bit_io(rd ? ~sdo : wd[k], r);
      q[k] = r;
    end
    #100 sel_n = 1'b1;
    #800;
  endtask
endmodule // dcrb_host
`default_nettype wire

// File: verif/dcrb_reg_bank_bench.sv
// Self-checking bench for the configuration register bank
`default_nettype none
module dcrb_reg_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic oe_pin = 1'b0;
  logic pd_pin = 1'b0;
  wire sel_n, sck, sdo;
  logic dout, doe, duty_cycle_stabilizer, fmt, oen, pda, spe;
  logic [7:0] ma, mb;
  // Shared data wire: the device wins while it enables its driver
  wire sdio = doe ? dout : sdo;
  int error_cnt = 0;
  int samples_checked = 0;
  // ==========================================================
  // Clock, host and device
  initial forever #20 clk = ~clk;
  dcrb_host host (.sel_n(sel_n), .sck(sck), .sdo(sdo), .sdio(sdio));
  dcrb_reg_bank dut (.REF_CLK(clk), .ARST_N(arst_n), .SERIAL_SELECT_N(sel_n), .SHIFT_CLOCK_FORMAT_STRAP(sck),
    .SERIAL_IO_STABILIZER_STRAP_IN(sdio), .SERIAL_IO_STABILIZER_STRAP_OUT(dout),
    .SERIAL_IO_STABILIZER_STRAP_OE(doe), .OUTPUT_DISABLE_PIN(oe_pin), .POWERDOWN_PIN(pd_pin),
    .DUTY_CYCLE_STABILIZER(duty_cycle_stabilizer), .DATA_FORMAT_SELECT(fmt), .DATA_OUTPUTS_ENABLE(oen),
    .POWERDOWN_ACTIVE(pda), .SERIAL_PORT_ENABLED(spe), .ACTIVE_MODES_A(ma), .ACTIVE_MODES_B(mb));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask
  // Straps must be steady before release; 10 edges covers capture at the 6th
  task automatic do_reset(input logic s, input logic c, input logic d);
    host.strap(s, c, d);
    @(posedge clk);
    #1 arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs about 0.32 ms
  initial begin
    #2000000;
    error_cnt++;
    print_verdict();
  end
  // ==========================================================
  // Test sequence
  initial begin
    do_reset(1'b0, 1'b0, 1'b0);
    host.strap(1'b1, 1'b0, 1'b0);
    chk(spe, 8'h01);
    chk(ma, 8'h80);
    chk(mb, 8'h80);
    chk(duty_cycle_stabilizer, 8'h01);
    chk(fmt, 8'h00);
    rd(13'h005, 8'h03);
    rd(13'h000, 8'h18);
    rd(13'h0FF, 8'h00);
    $display("Defaults test done");
    wr(13'h005, 8'h01);
    wr(13'h008, 8'h20);
    chk(ma, 8'h80);
    rd(13'h008, 8'h20);
    wr(13'h0FF, 8'h00);
    chk(ma, 8'h80);
    wr(13'h0FF, 8'h01);
    chk(ma, 8'h20);
    chk(mb, 8'h80);
    rd(13'h0FF, 8'h00);
    $display("Shadow test done");
    wr(13'h005, 8'h03);
    wr(13'h008, 8'h41);
    wr(13'h0FF, 8'h01);
    chk(ma, 8'h41);
    chk(mb, 8'h41);
    wr(13'h005, 8'h02);
    wr(13'h008, 8'h11);
    wr(13'h0FF, 8'h01);
    chk(mb, 8'h11);
    chk(ma, 8'h41);
    wr(13'h005, 8'h03);
    rd(13'h008, 8'h41);
    wr(13'h005, 8'h02);
    rd(13'h008, 8'h11);
    $display("Channel test done");
    wr(13'h005, 8'h01);
    wr(13'h100, 8'h5C);
    wr(13'h005, 8'h02);
    rd(13'h100, 8'h5C);
    rd(13'h11D, 8'h00);
    rd(13'h02E, 8'h00);
    rd(13'h013, 8'h00);
    wr(13'h005, 8'h01);
    wr(13'h014, 8'h01);
    wr(13'h009, 8'h00);
    chk(fmt, 8'h00);
    wr(13'h0FF, 8'h01);
    chk(fmt, 8'h01);
    chk(duty_cycle_stabilizer, 8'h00);
    $display("Map test done");
    // All four pin combinations
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1 oe_pin = i[1];
      pd_pin = i[0];
      repeat (6) @(posedge clk);
      #1 chk(oen, !i[1]);
      chk(pda, i[0]);
    end
    $display("Pin test done");
    wr(13'h000, 8'h5A);
    host.lsb = 1'b1;
    rd(13'h005, 8'h01);
    rd(13'h000, 8'h5A);
    wr(13'h000, 8'h3C);
    host.lsb = 1'b0;
    rd(13'h005, 8'h03);
    rd(13'h000, 8'h18);
    $display("Bit order test done");
    do_reset(1'b1, 1'b1, 1'b0);
    chk(spe, 8'h00);
    chk(duty_cycle_stabilizer, 8'h00);
    chk(fmt, 8'h01);
    host.strap(1'b1, 1'b0, 1'b1);
    repeat (20) @(posedge clk);
    #1 chk(duty_cycle_stabilizer, 8'h00);
    chk(fmt, 8'h01);
    do_reset(1'b1, 1'b0, 1'b1);
    chk(duty_cycle_stabilizer, 8'h01);
    chk(fmt, 8'h00);
    $display("Strap test done");
    print_verdict();
  end
endmodule // dcrb_reg_bank_bench
`default_nettype wire
